/* rtl/spl_consts.vh */
/*
  Constants for the sector protection logic: register offsets, field
  positions, command codes, reset values and timing counts.
  Assumes a 250 MHz system clock.
*/
`ifndef SPL_CONSTS_VH
`define SPL_CONSTS_VH

// Register offsets (byte addresses)
`define SPL_REG_STATUS 5'h00
`define SPL_REG_ADDR 5'h04
`define SPL_REG_CMD 5'h08
`define SPL_REG_RESULT 5'h0c
`define SPL_REG_PW_LO 5'h10
`define SPL_REG_PW_HI 5'h14

// Status fields
`define SPL_ST_BUSY 0
`define SPL_ST_LOCK 1
`define SPL_ST_PWMODE 2
`define SPL_ST_PERR 3
`define SPL_ST_PROT 4
`define SPL_ST_FAIL 5

// Command field: code in [2:0], dynamic value in bit 3
`define SPL_CMD_VAL 3
`define SPL_OP_PPROG 3'h1
`define SPL_OP_PERASE 3'h2
`define SPL_OP_PREAD 3'h3
`define SPL_OP_DWRITE 3'h4
`define SPL_OP_LCLR 3'h5
`define SPL_OP_UNLK 3'h6

// Mapping of the parameter blocks
`define SPL_UNITS 542
`define SPL_PARAM_TOP 8'hff
`define SPL_PARAM_BASE 10'd510

// Reset and factory values
`define SPL_BITS_ERASED 1'b1
`define SPL_LOCK_RST 1'b0

// Timing: figures in their own units, counts derived
`define SPL_CLK_MHZ 250
`define SPL_PROG_TIME_US 200
`define SPL_ERASE_TIME_US 40000
`define SPL_UNLK_TIME_US 100
`define SPL_READ_LAT_NS 20
`define SPL_PROG_CYC (`SPL_PROG_TIME_US * `SPL_CLK_MHZ)
`define SPL_ERASE_CYC (`SPL_ERASE_TIME_US * `SPL_CLK_MHZ)
`define SPL_UNLK_CYC (`SPL_UNLK_TIME_US * `SPL_CLK_MHZ)
`define SPL_READ_CYC ((`SPL_READ_LAT_NS * `SPL_CLK_MHZ + 999) / 1000)

`endif

/* rtl/spl_sector_protect.v */
/*
  Sector protection logic: persistent and dynamic bits per unit, a lock over the persistent bits, password unlock, array checks.
  Assumes a command decoder that drives both ports synchronously to clk_sys_in.
*/
`timescale 1ns/1ns
`include "spl_consts.vh"

module spl_sector_protect #(
  parameter [23:0] PROG_CYC = `SPL_PROG_CYC,
  parameter [23:0] ERASE_CYC = `SPL_ERASE_CYC,
  parameter [23:0] UNLK_CYC = `SPL_UNLK_CYC
) (
  // Clock and resets
  input wire clk_sys_in,
  input wire nrst_in,
  input wire cold_start_in,
  input wire sw_reset_in,
  // Straps and secrets
  input wire mode_pw_in,
  input wire [63:0] hidden_pw_in,
  // Register port
  input wire [4:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  // Array check port
  input wire arr_req_in,
  input wire arr_wr_in,
  input wire [24:0] arr_addr_in,
  output reg arr_ack_out,
  output reg arr_ok_out,
  // Status
  output reg busy_out
);

  // One-hot states of the sequencer
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_PROG = 7'h02;
  localparam [6:0] S_PREP = 7'h04;
  localparam [6:0] S_VERI = 7'h08;
  localparam [6:0] S_ERAS = 7'h10;
  localparam [6:0] S_READ = 7'h20;
  localparam [6:0] S_UNLK = 7'h40;
  localparam [23:0] RD_CYC = `SPL_READ_CYC;
  localparam N = `SPL_UNITS;

  // Unit of a byte address; low address bits are don't care
  function [9:0] unit_of;
    input [24:0] a;
    begin
      if (a[24:17] == `SPL_PARAM_TOP) begin
        unit_of = `SPL_PARAM_BASE + {5'h00, a[16:12]};
      end else begin
        unit_of = {1'b0, a[24:16]};
      end
    end
  endfunction

  reg [N-1:0] pbit; // Persistent bits, survive hardware reset unless cold start
  reg [N-1:0] dbit; // Dynamic bits, volatile
  reg [6:0] state; // Sequencer state
  reg [23:0] tmr; // Time left in the current step
  reg [9:0] unit; // Unit of the pending command
  reg [24:0] addr; // Address register
  reg [63:0] pw; // Supplied password
  reg lock; // Lock over the persistent bits
  reg lock_gone; // Lock cleared since hardware reset
  reg pw_mode; // Strap captured after reset
  reg init_pend; // Strap not yet captured
  reg perr; // Program error, sticky
  reg prot; // Protection error, sticky
  reg fail; // Last persistent operation failed
  reg rbit; // Last persistent bit read
  reg rvalid; // Read result ready

  // Decoded strobes
  wire cmd_wr = reg_wr_in && (reg_addr_in == `SPL_REG_CMD);
  wire st_wr = reg_wr_in && (reg_addr_in == `SPL_REG_STATUS);
  wire [2:0] op = reg_wdata_in[2:0];
  wire [9:0] cmd_unit = unit_of(addr);
  wire [9:0] arr_unit = unit_of(arr_addr_in);
  wire idle = (state == S_IDLE) && !init_pend;
  // Unlock allowed: password mode, no lock clear since reset, match
  wire pw_ok = pw_mode && !lock_gone && (pw == hidden_pw_in);
  // Events that set error bits this cycle
  reg set_perr;
  reg set_prot;
  reg set_fail;
  reg clr_fail;

  // Combined protection of the array's unit
  wire arr_prot;
  // dynamic counts only when persistent erased
  assign arr_prot = !(pbit[arr_unit] && dbit[arr_unit]);

  // Array request check, answered one cycle later
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      arr_ack_out <= 1'b0;
      arr_ok_out <= 1'b0;
    end else begin
      arr_ack_out <= arr_req_in;
      arr_ok_out <= arr_req_in && (arr_wr_in ? !arr_prot : (state != S_PROG));
    end
  end

  // Error events from the command path
  always @* begin
    set_perr = 1'b0;
    set_prot = 1'b0;
    set_fail = 1'b0;
    clr_fail = 1'b0;
    if (cmd_wr && idle && (op == `SPL_OP_PPROG || op == `SPL_OP_PERASE)) begin
      set_perr = !lock;
      set_prot = !lock;
      set_fail = !lock;
      clr_fail = lock;
    end else if (cmd_wr && idle && op == `SPL_OP_UNLK) begin
      // wrong password or no right to unlock
      set_perr = !pw_ok;
      set_prot = !pw_ok;
    end
  end

  // Sticky error bits; a set in the clearing cycle wins
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      perr <= 1'b0;
      prot <= 1'b0;
      fail <= 1'b0;
    end else begin
      // A set in the same cycle beats a write-one clear
      perr <= set_perr || (perr && !(st_wr && reg_wdata_in[`SPL_ST_PERR]));
      prot <= set_prot || (prot && !(st_wr && reg_wdata_in[`SPL_ST_PROT]));
      fail <= set_fail || (fail && !clr_fail);
    end
  end

  // Lock bit and mode strap
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      // Strap is a port, so it is caught after release
      lock <= `SPL_LOCK_RST;
      lock_gone <= 1'b0;
      pw_mode <= 1'b0;
      init_pend <= 1'b1;
    end else if (init_pend) begin
      init_pend <= 1'b0;
      pw_mode <= mode_pw_in;
      lock <= ~mode_pw_in;
    end else if (cmd_wr && idle && op == `SPL_OP_LCLR) begin
      // lock clear, no command sets it back
      lock <= 1'b0;
      lock_gone <= 1'b1;
    end else if (cmd_wr && idle && op == `SPL_OP_UNLK) begin
      // only a matching password sets the lock
      if (pw_ok) begin
        lock <= 1'b1;
      end
    end
    // software reset does not touch the lock
  end

  // Address and password registers
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      addr <= 25'h0000000;
      pw <= 64'h0000000000000000;
    end else if (reg_wr_in) begin
      // address taken as given by the host
      if (reg_addr_in == `SPL_REG_ADDR) begin
        addr <= reg_wdata_in[24:0];
      end
      if (reg_addr_in == `SPL_REG_PW_LO) begin
        pw[31:0] <= reg_wdata_in;
      end
      if (reg_addr_in == `SPL_REG_PW_HI) begin
        pw[63:32] <= reg_wdata_in;
      end
    end
  end

  // Dynamic bits, volatile; resets set every dynamic bit to unprotect
  always @(posedge clk_sys_in) begin
    if (!nrst_in || sw_reset_in) begin
      dbit <= {N{1'b1}};
    end else if (cmd_wr && idle && op == `SPL_OP_DWRITE) begin
      // write zero to protect, one to unprotect
      dbit[cmd_unit] <= reg_wdata_in[`SPL_CMD_VAL];
    end
  end

  // Sequencer for persistent bit program, erase, read, unlock delay.
  // On reset, persistent bits take the erased value only on a cold start, as
  // a stand-in for the factory state; plain hardware reset keeps them.
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state <= S_IDLE;
      tmr <= 24'h000000;
      unit <= 10'h000;
      rbit <= 1'b0;
      rvalid <= 1'b0;
      busy_out <= 1'b0;
      if (cold_start_in) begin
        pbit <= {N{`SPL_BITS_ERASED}};
      end
    end else begin
      // Shared countdown; a state that loads the timer overrides it
      if (tmr != 24'h000000) begin
        tmr <= tmr - 24'h000001;
      end
      case (state)
        S_IDLE: begin
          if (cmd_wr && idle) begin
            unit <= cmd_unit;
            case (op)
              `SPL_OP_PPROG, `SPL_OP_PERASE: begin
                // lock one lets persistent bits change
                if (lock) begin
                  tmr <= PROG_CYC - 24'h000001;
                  state <= (op == `SPL_OP_PPROG) ? S_PROG : S_PREP;
                  busy_out <= 1'b1;
                end
              end
              `SPL_OP_PREAD: begin
                tmr <= RD_CYC - 24'h000001;
                rvalid <= 1'b0;
                state <= S_READ;
                busy_out <= 1'b1;
              end
              `SPL_OP_UNLK: begin
                // Failed unlock holds off the next try
                if (!pw_ok) begin
                  tmr <= UNLK_CYC - 24'h000001;
                  state <= S_UNLK;
                  busy_out <= 1'b1;
                end
              end
              default: begin
                state <= S_IDLE;
              end
            endcase
          end
        end
        S_PROG: begin
          if (tmr == 24'h000000) begin
            // program drives one bit to zero
            pbit[unit] <= 1'b0;
            state <= S_IDLE;
            busy_out <= 1'b0;
          end
        end
        S_PREP: begin
          if (tmr == 24'h000000) begin
            pbit <= {N{1'b0}};
            state <= S_VERI;
          end
        end
        S_VERI: begin
          // Verify preprogram; retry it if any bit is still set
          if (pbit == {N{1'b0}}) begin
            tmr <= ERASE_CYC - 24'h000001;
            state <= S_ERAS;
          end else begin
            tmr <= PROG_CYC - 24'h000001;
            state <= S_PREP;
          end
        end
        S_ERAS: begin
          if (tmr == 24'h000000) begin
            pbit <= {N{`SPL_BITS_ERASED}};
            state <= S_IDLE;
            busy_out <= 1'b0;
          end
        end
        S_READ: begin
          if (tmr == 24'h000000) begin
            rbit <= pbit[unit];
            rvalid <= 1'b1;
            state <= S_IDLE;
            busy_out <= 1'b0;
          end
        end
        S_UNLK: begin
          if (tmr == 24'h000000) begin
            state <= S_IDLE;
            busy_out <= 1'b0;
          end
        end
        default: begin
          state <= S_IDLE;
          busy_out <= 1'b0;
        end
      endcase
    end
  end

  // Register read, data one cycle after the strobe only
  always @(posedge clk_sys_in) begin
    if (!nrst_in || !reg_rd_in) begin
      reg_rdata_out <= 32'h00000000;
    end else begin
      case (reg_addr_in)
        `SPL_REG_STATUS: begin
          // progress shows in the busy bit
          reg_rdata_out <= {26'h0000000, fail, prot, perr,
                            pw_mode, lock, busy_out};
        end
        `SPL_REG_ADDR: begin
          reg_rdata_out <= {7'h00, addr};
        end
        `SPL_REG_RESULT: begin
          reg_rdata_out <= {30'h00000000, rvalid, rbit};
        end
        default: begin
          // Command and password read as zero
          reg_rdata_out <= 32'h00000000;
        end
      endcase
    end
  end

endmodule // spl_sector_protect

/* verif/spl_sector_protect_monitor.sv */
/*
  Checker for the sector protection logic, bound to its top module.
  Assumes the short timing parameters are handed on by the bind.
*/
`timescale 1ns/1ns
`include "spl_consts.vh"
module spl_sector_protect_monitor #(
  parameter [23:0] PROG_CYC = 24'h8,
  parameter [23:0] ERASE_CYC = 24'h10,
  parameter [23:0] UNLK_CYC = 24'h8
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire nrst_in,
  // Register port
  input wire [4:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [31:0] reg_rdata_out,
  // Array check port
  input wire arr_req_in,
  input wire arr_ack_out,
  input wire arr_ok_out,
  // Status
  input wire busy_out
);
  // Cycles in the current busy run
  int busy_len;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // Run length restarts whenever busy drops
  always @(posedge clk_sys_in) begin
    if (!nrst_in || !busy_out) begin
      busy_len <= 0;
    end else begin
      busy_len <= busy_len + 1;
    end
  end
  // Read command taken while idle, not in the strap cycle
  sequence s_rd_cmd;
    reg_wr_in && reg_addr_in == `SPL_REG_CMD && reg_wdata_in[2:0] == `SPL_OP_PREAD && !busy_out && $past(nrst_in);
  endsequence
  // Access latency then idle again
  sequence s_rd_busy;
    busy_out [*5] ##1 !busy_out;
  endsequence
  AST_ACK_NEXT: assert property (arr_req_in |=> arr_ack_out) else $error("check not answered");
  AST_ACK_ONLY: assert property (!arr_req_in |=> !arr_ack_out && !arr_ok_out) else $error("stray ack");
  AST_RD_STANDS: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0) else $error("stale data");
  AST_ST_BUSY: assert property (reg_rd_in && reg_addr_in == `SPL_REG_STATUS |=>
    reg_rdata_out[`SPL_ST_BUSY] == $past(busy_out)) else $error("busy bit wrong");
  AST_BUSY_LEN: assert property ($fell(busy_out) |-> busy_len == 5 || busy_len == PROG_CYC ||
    busy_len == PROG_CYC + ERASE_CYC + 1 || busy_len == UNLK_CYC) else $error("busy length wrong");
  AST_BUSY_MAX: assert property (busy_len <= PROG_CYC + ERASE_CYC + 1) else $error("busy too long");
  AST_RD_LAT: assert property (s_rd_cmd |=> s_rd_busy) else $error("read latency wrong");
  AST_QUIET_CMD: assert property (reg_wr_in && reg_addr_in == `SPL_REG_CMD && !busy_out &&
    (reg_wdata_in[2:0] == `SPL_OP_DWRITE || reg_wdata_in[2:0] == `SPL_OP_LCLR) |=> !busy_out) else $error("busy");
endmodule // spl_sector_protect_monitor

bind spl_sector_protect spl_sector_protect_monitor #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC),
  .UNLK_CYC(UNLK_CYC)) u_mon (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .arr_req_in(arr_req_in), .arr_ack_out(arr_ack_out), .arr_ok_out(arr_ok_out), .busy_out(busy_out));

/* verif/spl_host.sv */
/*
  Host model: drives the register port and the array check port.
  Assumes read data and array answers come one cycle after the strobe.
*/
`timescale 1ns/1ns
module spl_host (
  // Clock
  input wire clk_sys_in,
  // Register port
  output logic [4:0] ra_out = 5'h0,
  output logic [31:0] wd_out = 32'h0,
  output logic we_out = 1'b0,
  output logic re_out = 1'b0,
  input wire [31:0] rd_in,
  // Array check port
  output logic rq_out = 1'b0,
  output logic aw_out = 1'b0,
  output logic [24:0] aa_out = 25'h0,
  input wire ack_in,
  input wire ok_in
);
  // One-cycle write strobe
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    we_out <= 1'b1;
    ra_out <= a;
    wd_out <= d;
    @(posedge clk_sys_in);
    we_out <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    @(posedge clk_sys_in);
    re_out <= 1'b1;
    ra_out <= a;
    @(posedge clk_sys_in);
    re_out <= 1'b0;
    #1 q = rd_in;
  endtask
  task automatic chk_arr(input logic w, input logic [24:0] a, output logic [31:0] q);
    @(posedge clk_sys_in);
    rq_out <= 1'b1;
    aw_out <= w;
    aa_out <= a;
    @(posedge clk_sys_in);
    rq_out <= 1'b0;
    #1 q = {30'h0, ack_in, ok_in};
  endtask
endmodule // spl_host

/* verif/spl_sector_protect_tb.sv */
/*
  Self-checking bench for the sector protection logic.
  Assumes the host model and short program, erase and unlock counts.
*/
`timescale 1ns/1ns
`include "spl_consts.vh"
module spl_sector_protect_tb;
  // Clock, resets and straps
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic cold_start_in = 1'b1;
  logic sw_reset_in = 1'b0;
  logic mode_pw_in = 1'b0;
  // Stored password, value is arbitrary
  logic [63:0] pw = 64'h0123456789abcdef;
  // Host side wires
  wire [4:0] ra;
  wire [31:0] wd;
  wire [31:0] rd;
  wire [24:0] aa;
  wire we, re, rq, aw, ack, ok, busy;
  int num_errors = 0;
  int checked = 0;
  logic [31:0] q;
  always #2 clk_sys_in = ~clk_sys_in;
  spl_sector_protect #(.PROG_CYC(24'h8), .ERASE_CYC(24'h10), .UNLK_CYC(24'h8)) dut (.clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in), .cold_start_in(cold_start_in), .sw_reset_in(sw_reset_in), .mode_pw_in(mode_pw_in),
    .hidden_pw_in(pw), .reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(we), .reg_rd_in(re), .reg_rdata_out(rd),
    .arr_req_in(rq), .arr_wr_in(aw), .arr_addr_in(aa), .arr_ack_out(ack), .arr_ok_out(ok), .busy_out(busy));
  spl_host host (.clk_sys_in(clk_sys_in), .ra_out(ra), .wd_out(wd), .we_out(we), .re_out(re), .rd_in(rd),
    .rq_out(rq), .aw_out(aw), .aa_out(aa), .ack_in(ack), .ok_in(ok));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] e);
    host.rd(a, q);
    chk(q, e);
  endtask
  // Array check must be answered with the given verdict
  task automatic ac(input logic w, input logic [24:0] a, input logic e);
    host.chk_arr(w, a, q);
    chk(q, {30'h0, 1'b1, e});
  endtask
  // Bounded wait for the sequencer to go idle
  task automatic wb;
    int i;
    i = 0;
    #1;
    while (busy !== 1'b0 && i < 100) begin
      @(posedge clk_sys_in);
      #1 i++;
    end
    if (i == 100) num_errors++;
  endtask
  task automatic cmd(input logic [2:0] op, input logic v, input logic [24:0] a);
    host.wr(`SPL_REG_ADDR, {7'h0, a});
    host.wr(`SPL_REG_CMD, {28'h0, v, op});
    wb;
  endtask
  // Hardware reset; cold start also restores persistent bits
  task automatic hw(input logic m, input logic c);
    @(posedge clk_sys_in);
    nrst_in <= 1'b0;
    cold_start_in <= c;
    mode_pw_in <= m;
    repeat (3) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    cold_start_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
  endtask
  // One-cycle software reset pulse
  task automatic sr;
    @(posedge clk_sys_in);
    sw_reset_in <= 1'b1;
    @(posedge clk_sys_in);
    sw_reset_in <= 1'b0;
  endtask
  task automatic end_sim;
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    hw(1'b0, 1'b1);
    rc(`SPL_REG_STATUS, 32'h2);
    ac(1'b1, 25'h0, 1'b1);
    ac(1'b1, 25'h1fdffff, 1'b1);
    cmd(`SPL_OP_PREAD, 1'b0, 25'h1fe0000);
    rc(`SPL_REG_RESULT, 32'h3);
    host.wr(`SPL_REG_ADDR, 32'h1fe0000);
    host.wr(`SPL_REG_CMD, {29'h0, `SPL_OP_PPROG});
    ac(1'b0, 25'h0, 1'b0);
    rc(`SPL_REG_STATUS, 32'h3);
    wb;
    ac(1'b0, 25'h0, 1'b1);
    ac(1'b1, 25'h1fe0fff, 1'b0);
    ac(1'b1, 25'h1fe1000, 1'b1);
    cmd(`SPL_OP_PREAD, 1'b0, 25'h1fe0000);
    rc(`SPL_REG_RESULT, 32'h2);
    cmd(`SPL_OP_DWRITE, 1'b1, 25'h1fe0000);
    ac(1'b1, 25'h1fe0000, 1'b0);
    cmd(`SPL_OP_DWRITE, 1'b0, 25'h50000);
    ac(1'b1, 25'h5ffff, 1'b0);
    ac(1'b1, 25'h60000, 1'b1);
    cmd(`SPL_OP_DWRITE, 1'b1, 25'h50000);
    ac(1'b1, 25'h50000, 1'b1);
    cmd(`SPL_OP_PERASE, 1'b0, 25'h50000);
    ac(1'b1, 25'h1fe0000, 1'b1);
    cmd(`SPL_OP_DWRITE, 1'b0, 25'h0);
    cmd(`SPL_OP_LCLR, 1'b0, 25'h0);
    rc(`SPL_REG_STATUS, 32'h0);
    cmd(`SPL_OP_PPROG, 1'b0, 25'h10000);
    rc(`SPL_REG_STATUS, 32'h38);
    ac(1'b1, 25'h10000, 1'b1);
    cmd(`SPL_OP_UNLK, 1'b0, 25'h0);
    host.wr(`SPL_REG_STATUS, 32'h18);
    rc(`SPL_REG_STATUS, 32'h20);
    // Software reset frees dynamic bits, lock unchanged
    sr;
    rc(`SPL_REG_STATUS, 32'h20);
    ac(1'b1, 25'h0, 1'b1);
    hw(1'b1, 1'b0);
    rc(`SPL_REG_STATUS, 32'h4);
    host.wr(`SPL_REG_PW_LO, 32'h89abcdef);
    host.wr(`SPL_REG_PW_HI, 32'h01234566);
    cmd(`SPL_OP_UNLK, 1'b0, 25'h0);
    rc(`SPL_REG_STATUS, 32'h1c);
    host.wr(`SPL_REG_STATUS, 32'h18);
    host.wr(`SPL_REG_PW_HI, 32'h01234567);
    cmd(`SPL_OP_UNLK, 1'b0, 25'h0);
    rc(`SPL_REG_STATUS, 32'h6);
    // A set lock must survive a software reset too
    sr;
    rc(`SPL_REG_STATUS, 32'h6);
    cmd(`SPL_OP_PPROG, 1'b0, 25'h10000);
    ac(1'b1, 25'h10000, 1'b0);
    cmd(`SPL_OP_LCLR, 1'b0, 25'h0);
    cmd(`SPL_OP_UNLK, 1'b0, 25'h0);
    rc(`SPL_REG_STATUS, 32'h1c);
    end_sim;
  end
  // Run takes under 1500 cycles; cut a hang well beyond that
  initial begin
    #50000;
    num_errors++;
    end_sim;
  end
endmodule // spl_sector_protect_tb
